// ===== pipe_sb_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PIPE_SB_MAP_SVH
`define PIPE_SB_MAP_SVH

`define RA_CTRL 4'h0
`define RA_P2_IN 4'h1
`define RA_P2_OUT 4'h2
`define RA_NONP2 4'h3
`define RA_STAT 4'h4
`define RA_MASK 4'h5
`define RA_STATE 4'h6

`define CTRL_RST 16'h0042
`define P2_IN_RST 16'h0064
`define P2_OUT_RST 16'h003c
`define NONP2_RST 16'h0019
`define ZERO16 16'h0000

`define CB_SATA 0
`define CB_OOB 1
`define CB_CHK 2
`define CB_LOOP 3
`define CF_BURST 6:4

`define EV_PHY 0
`define EV_INIT 1
`define EV_SAS 2
`define EV_WAKE 3
`define EV_PERR 4
`define EV_SEND 5
`define EV_W 6

`define PWR_P0 2'h0
`define PWR_P1 2'h2
`define PWR_P2 2'h3

`define LB_NEAR_PCS 3'h1
`define LB_NEAR_PMA 3'h2
`define LB_FAR_PMA 3'h4
`define LB_FAR_PCS 3'h6

`define SC_OK 3'h0
`define SC_PCIE_DET 3'h3
`define SC_ERR 3'h4
`define SC_SATA_INIT 3'h1
`define SC_SATA_WAKE 3'h2
`define SC_SATA_SAS 3'h3

`define OC_NONE 2'h0
`define OC_WAKE 2'h1
`define OC_INIT 2'h2
`define OC_SAS 2'h3

`define CLK_NS 8
`define RXDET_NS 1000
`define RXDET_CYC ((`RXDET_NS + `CLK_NS - 1) / `CLK_NS)
`define BURST_NS 104
`define BURST_CYC ((`BURST_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_GAP_NS 104
`define WAKE_GAP_CYC ((`WAKE_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_GAP_NS 320
`define INIT_GAP_CYC ((`INIT_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define SAS_GAP_NS 960
`define SAS_GAP_CYC ((`SAS_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_MIN_NS 56
`define WAKE_MIN_CYC ((`WAKE_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_MIN_NS 200
`define INIT_MIN_CYC ((`INIT_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define SAS_MIN_NS 640
`define SAS_MIN_CYC ((`SAS_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define SAS_MAX_NS 1500
`define SAS_MAX_CYC (`SAS_MAX_NS / `CLK_NS)

`define PS_OFF 3'h0
`define PS_7 3'h1
`define PS_15 3'h2
`define PS_23 3'h3
`define PS_31 3'h4
`define T7A 6
`define T7B 5
`define T15A 14
`define T15B 13
`define T23A 22
`define T23B 17
`define T31A 30
`define T31B 27
`define PRBS_SEED 31'h7fffffff

`endif

// ===== pipe_sb_pkg.sv
// Types shared by the lane sideband logic
package pipe_sb_pkg;
  typedef logic [15:0] word_t;
  typedef logic [1:0] pwr_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PWR = 2'b01,
    ST_DET = 2'b10
  } op_state_t;
  typedef enum logic [1:0] {
    SD_IDLE = 2'b00,
    SD_BURST = 2'b01,
    SD_GAP = 2'b10
  } send_state_t;
endpackage : pipe_sb_pkg

// ===== prbs_lane.sv
// Pseudo-random pattern generator and self-synchronising checker
`timescale 1ns/1ps
`include "pipe_sb_map.svh"
module prbs_lane (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] sel,
  input wire logic inject,
  input wire logic chk_en,
  input wire logic rx_bit,
  output logic tx_bit,
  output logic err
);
  logic [30:0] gen;
  logic [30:0] chk;
  logic gen_fb;
  logic chk_fb;

  function automatic logic fb(input logic [30:0] s, input logic [2:0] ps);
    case (ps)
      `PS_7: fb = s[`T7A] ^ s[`T7B];
      `PS_15: fb = s[`T15A] ^ s[`T15B];
      `PS_23: fb = s[`T23A] ^ s[`T23B];
      `PS_31: fb = s[`T31A] ^ s[`T31B];
      default: fb = 1'b0;
    endcase
  endfunction : fb

  assign gen_fb = fb(gen, sel);
  assign chk_fb = fb(chk, sel);

  always_ff @(posedge sys_clk) begin
    if (rst || sel == `PS_OFF) begin
      gen <= `PRBS_SEED;
      tx_bit <= 1'b0;
    end else begin
      gen <= {gen[29:0], gen_fb};
      tx_bit <= gen_fb ^ inject;
    end
  end

  // Checker predicts each bit from the last received ones
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chk <= `PRBS_SEED;
      err <= 1'b0;
    end else begin
      chk <= {chk[29:0], rx_bit};
      err <= chk_en && sel != `PS_OFF && rx_bit != chk_fb;
    end
  end
endmodule : prbs_lane

// ===== lane_sideband.sv
// Lane sideband control: power timing, detect, out-of-band, test patterns
// Notes on behaviour
// - P2 entry count, 0..65535, default 100
// - P2 exit count, 0..65535, default 60
// - Other power transitions count, default 25
// - Three-bit loopback select enables a test path
// - Three-bit status code follows chosen format
// - Valid only with symbol lock and data
// - Separate init, SAS and wake detect flags
// - Detect depends on power, idle, disparity
// - Detect request ignored in SATA format
// - Idle request forces transmitter electrical idle
// - Pulse completion after detect or power change
// - Out-of-band detector enable, both protocols
// - Optional receive pattern checker for self test
// - Pattern select chooses transmitted sequence
// - Force-error input corrupts transmitted pattern
// - Error-loop routes receive error to inject
// - COM match after configured burst count
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "pipe_sb_map.svh"
module lane_sideband (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire pipe_sb_pkg::word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pipe_sb_pkg::word_t reg_rdata,
  output logic irq,
  input wire pipe_sb_pkg::pwr_t tx_power_state,
  input wire pipe_sb_pkg::pwr_t rx_power_state,
  input wire logic tx_idle_request,
  input wire logic tx_disparity_mode,
  input wire logic tx_disparity_value,
  input wire logic far_receiver_detect_req,
  input wire logic [2:0] loopback_select,
  input wire logic oob_init_send,
  input wire logic oob_sas_send,
  input wire logic oob_wake_send,
  input wire logic [2:0] tx_pattern_select,
  input wire logic tx_pattern_inject_error,
  input wire logic rx_lock_in,
  input wire logic rx_data_valid_in,
  input wire logic [31:0] rx_word_in,
  input wire logic [3:0] rx_k_in,
  input wire logic rx_pattern_bit_in,
  input wire logic oob_squelch_pin,
  input wire logic far_present_pin,
  output logic [2:0] rx_status_code,
  output logic rx_symbol_valid,
  output logic [31:0] rx_word,
  output logic [3:0] rx_control_char_flags,
  output logic oob_init_detected,
  output logic oob_sas_detected,
  output logic oob_wake_detected,
  output logic oob_send_done,
  output logic phy_op_complete,
  output logic tx_elec_idle,
  output logic tx_oob_burst,
  output logic [3:0] loopback_path,
  output logic tx_pattern_bit,
  output logic rx_pattern_error
);
  import pipe_sb_pkg::*;

  word_t ctrl;
  word_t p2_in;
  word_t p2_out;
  word_t nonp2;
  logic [`EV_W-1:0] stat;
  logic [`EV_W-1:0] mask;
  logic [`EV_W-1:0] ev;
  op_state_t state;
  word_t op_cnt;
  pwr_t pwr_prev;
  logic pwr_chg;
  logic det_ok;
  logic op_done;
  logic sq_meta, sq_s, sq_d;
  logic fp_meta, fp_s;
  logic [7:0] gap;
  logic [2:0] burst_cnt;
  logic [1:0] last_cls;
  logic [1:0] cls;
  logic [3:0] next_burst;
  logic oob_hit;
  send_state_t sd_state;
  logic [7:0] sd_cnt;
  logic [7:0] sd_gap;
  logic [2:0] sd_left;
  logic inject_eff;
  logic chk_rx_bit;
  logic sata;

  assign sata = ctrl[`CB_SATA];

  function automatic logic [1:0] gap_class(input logic [7:0] g);
    if (g < 8'(`WAKE_MIN_CYC)) gap_class = `OC_NONE;
    else if (g < 8'(`INIT_MIN_CYC)) gap_class = `OC_WAKE;
    else if (g < 8'(`SAS_MIN_CYC)) gap_class = `OC_INIT;
    else if (g <= 8'(`SAS_MAX_CYC)) gap_class = `OC_SAS;
    else gap_class = `OC_NONE;
  endfunction : gap_class

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= `CTRL_RST;
      p2_in <= `P2_IN_RST;
      p2_out <= `P2_OUT_RST;
      nonp2 <= `NONP2_RST;
      mask <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `RA_CTRL: ctrl <= reg_wdata;
        `RA_P2_IN: p2_in <= reg_wdata;
        `RA_P2_OUT: p2_out <= reg_wdata;
        `RA_NONP2: nonp2 <= reg_wdata;
        `RA_MASK: mask <= reg_wdata[`EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Register reads, one cycle later; status clears on read, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `RA_CTRL: reg_rdata <= ctrl;
        `RA_P2_IN: reg_rdata <= p2_in;
        `RA_P2_OUT: reg_rdata <= p2_out;
        `RA_NONP2: reg_rdata <= nonp2;
        `RA_STAT: reg_rdata <= 16'(stat);
        `RA_MASK: reg_rdata <= 16'(mask);
        `RA_STATE: reg_rdata <= {5'h00, rx_lock_in, loopback_path,
          rx_status_code, state, sd_state != SD_IDLE};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign ev = {oob_send_done, rx_pattern_error, oob_wake_detected,
    oob_sas_detected, oob_init_detected, phy_op_complete};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat <= '0;
      irq <= 1'b0;
    end else begin
      stat <= ((reg_rd && reg_addr == `RA_STAT) ? '0 : stat) | ev;
      irq <= |(stat & mask);
    end
  end

  // Two-flop synchronisers for pins from the analog side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sq_meta <= 1'b0;
      sq_s <= 1'b0;
      sq_d <= 1'b0;
      fp_meta <= 1'b0;
      fp_s <= 1'b0;
    end else begin
      sq_meta <= oob_squelch_pin;
      sq_s <= sq_meta;
      sq_d <= sq_s;
      fp_meta <= far_present_pin;
      fp_s <= fp_meta;
    end
  end

  // Power-state change and receiver-detect sequencing
  assign pwr_chg = tx_power_state != pwr_prev;
  assign det_ok = far_receiver_detect_req && !sata
    && tx_power_state == `PWR_P1 && rx_power_state == `PWR_P1
    && tx_idle_request && !tx_disparity_mode
    && !tx_disparity_value;
  assign op_done = (state == ST_PWR || state == ST_DET) && op_cnt == '0
    && !pwr_chg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      op_cnt <= '0;
      pwr_prev <= `PWR_P0;
    end else begin
      pwr_prev <= tx_power_state;
      if (pwr_chg) begin
        state <= ST_PWR;
        if (tx_power_state == `PWR_P2) op_cnt <= p2_in;
        else if (pwr_prev == `PWR_P2) op_cnt <= p2_out;
        else op_cnt <= nonp2;
      end else begin
        case (state)
          ST_IDLE: begin
            if (det_ok) begin
              state <= ST_DET;
              op_cnt <= 16'(`RXDET_CYC - 1);
            end
          end
          ST_PWR, ST_DET: begin
            if (op_cnt == '0) state <= ST_IDLE;
            else op_cnt <= op_cnt - 16'h0001;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) phy_op_complete <= 1'b0;
    else phy_op_complete <= op_done;
  end

  // Status code in the selected format
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_status_code <= `SC_OK;
    end else if (!sata) begin
      if (op_done && state == ST_DET && fp_s)
        rx_status_code <= `SC_PCIE_DET;
      else if (rx_pattern_error) rx_status_code <= `SC_ERR;
      else rx_status_code <= `SC_OK;
    end else begin
      if (oob_hit && cls == `OC_INIT) rx_status_code <= `SC_SATA_INIT;
      else if (oob_hit && cls == `OC_WAKE)
        rx_status_code <= `SC_SATA_WAKE;
      else if (oob_hit && cls == `OC_SAS) rx_status_code <= `SC_SATA_SAS;
      else if (rx_pattern_error) rx_status_code <= `SC_ERR;
      else rx_status_code <= `SC_OK;
    end
  end

  // Receive word and valid
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_symbol_valid <= 1'b0;
      rx_word <= '0;
      rx_control_char_flags <= '0;
    end else begin
      rx_symbol_valid <= rx_lock_in && rx_data_valid_in;
      rx_word <= rx_word_in;
      rx_control_char_flags <= rx_k_in;
    end
  end

  // Out-of-band detect: classify each idle gap, count matching bursts
  assign cls = gap_class(gap);
  assign next_burst = (cls == last_cls) ? 4'(burst_cnt) + 4'h1 : 4'h1;
  assign oob_hit = ctrl[`CB_OOB] && sq_s && !sq_d && cls != `OC_NONE
    && next_burst >= 4'(ctrl[`CF_BURST]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap <= '0;
      burst_cnt <= '0;
      last_cls <= `OC_NONE;
    end else begin
      if (sq_s) gap <= '0;
      else if (gap != 8'hff) gap <= gap + 8'h01;
      if (!ctrl[`CB_OOB]) begin
        burst_cnt <= '0;
        last_cls <= `OC_NONE;
      end else if (sq_s && !sq_d) begin
        last_cls <= cls;
        if (cls == `OC_NONE || oob_hit) burst_cnt <= '0;
        else burst_cnt <= next_burst[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oob_init_detected <= 1'b0;
      oob_sas_detected <= 1'b0;
      oob_wake_detected <= 1'b0;
    end else begin
      oob_init_detected <= oob_hit && cls == `OC_INIT;
      oob_sas_detected <= oob_hit && cls == `OC_SAS;
      oob_wake_detected <= oob_hit && cls == `OC_WAKE;
    end
  end

  // Out-of-band transmit: bursts separated by gaps, then done pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sd_state <= SD_IDLE;
      sd_cnt <= '0;
      sd_gap <= '0;
      sd_left <= '0;
      tx_oob_burst <= 1'b0;
      oob_send_done <= 1'b0;
    end else begin
      oob_send_done <= 1'b0;
      case (sd_state)
        SD_IDLE: begin
          if (oob_init_send || oob_sas_send || oob_wake_send) begin
            if (oob_init_send) sd_gap <= 8'(`INIT_GAP_CYC);
            else if (oob_sas_send) sd_gap <= 8'(`SAS_GAP_CYC);
            else sd_gap <= 8'(`WAKE_GAP_CYC);
            sd_left <= ctrl[`CF_BURST];
            sd_cnt <= 8'(`BURST_CYC - 1);
            if (ctrl[`CF_BURST] == 3'h0) begin
              oob_send_done <= 1'b1;
            end else begin
              sd_state <= SD_BURST;
              tx_oob_burst <= 1'b1;
            end
          end
        end
        SD_BURST: begin
          if (sd_cnt == '0) begin
            sd_state <= SD_GAP;
            sd_cnt <= sd_gap - 8'h01;
            tx_oob_burst <= 1'b0;
          end else begin
            sd_cnt <= sd_cnt - 8'h01;
          end
        end
        SD_GAP: begin
          if (sd_cnt != '0) begin
            sd_cnt <= sd_cnt - 8'h01;
          end else if (sd_left == 3'h1) begin
            sd_state <= SD_IDLE;
            oob_send_done <= 1'b1;
          end else begin
            sd_left <= sd_left - 3'h1;
            sd_state <= SD_BURST;
            sd_cnt <= 8'(`BURST_CYC - 1);
            tx_oob_burst <= 1'b1;
          end
        end
        default: sd_state <= SD_IDLE;
      endcase
    end
  end

  // Electrical idle and loopback path decode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_elec_idle <= 1'b1;
      loopback_path <= '0;
    end else begin
      tx_elec_idle <= tx_idle_request
        || (!sata && tx_power_state != `PWR_P0);
      case (loopback_select)
        `LB_NEAR_PCS: loopback_path <= 4'h1;
        `LB_NEAR_PMA: loopback_path <= 4'h2;
        `LB_FAR_PMA: loopback_path <= 4'h4;
        `LB_FAR_PCS: loopback_path <= 4'h8;
        default: loopback_path <= 4'h0;
      endcase
    end
  end

  // Pattern test; near-end PCS loopback feeds the checker from the generator
  assign inject_eff = tx_pattern_inject_error
    || (ctrl[`CB_LOOP] && rx_pattern_error);
  assign chk_rx_bit = loopback_path[0] ? tx_pattern_bit : rx_pattern_bit_in;

  prbs_lane u_prbs (
    .sys_clk(sys_clk),
    .rst(rst),
    .sel(tx_pattern_select),
    .inject(inject_eff),
    .chk_en(ctrl[`CB_CHK]),
    .rx_bit(chk_rx_bit),
    .tx_bit(tx_pattern_bit),
    .err(rx_pattern_error)
  );

  a_p2_entry_load: assert property (@(posedge sys_clk) disable iff (rst)
    pwr_chg && tx_power_state == `PWR_P2 |=> op_cnt == $past(p2_in))
    else $error("P2 entry count not loaded");
  a_p2_exit_load: assert property (@(posedge sys_clk) disable iff (rst)
    pwr_chg && pwr_prev == `PWR_P2 && tx_power_state != `PWR_P2
    |=> state == ST_PWR && op_cnt == $past(p2_out))
    else $error("P2 exit count not loaded");
  a_nonp2_load: assert property (@(posedge sys_clk) disable iff (rst)
    pwr_chg && pwr_prev != `PWR_P2 && tx_power_state != `PWR_P2
    |=> op_cnt == $past(nonp2))
    else $error("Non-P2 count not loaded");
  a_op_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_PWR && op_cnt == 16'h0001 && !pwr_chg
    ##1 !pwr_chg |=> phy_op_complete ##1 !phy_op_complete)
    else $error("Completion pulse wrong");
  a_valid_lock: assert property (@(posedge sys_clk) disable iff (rst)
    rx_symbol_valid |-> $past(rx_lock_in) && $past(rx_data_valid_in))
    else $error("Valid without lock");
  a_sata_no_det: assert property (@(posedge sys_clk) disable iff (rst)
    sata && state == ST_IDLE && !pwr_chg |=> state != ST_DET)
    else $error("Detect started in SATA format");
  a_det_window: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_IDLE && det_ok && !pwr_chg |=> state == ST_DET
    && op_cnt == 16'(`RXDET_CYC - 1))
    else $error("Detect not started");
  a_err_loop: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl[`CB_LOOP] && rx_pattern_error && tx_pattern_select != `PS_OFF
    |=> tx_pattern_bit == !$past(u_prbs.gen_fb))
    else $error("Error loop did not inject");
  a_oob_gated: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(ctrl[`CB_OOB]) |-> !oob_init_detected && !oob_wake_detected
    && !oob_sas_detected)
    else $error("OOB flag while detector off");
  a_loop_near: assert property (@(posedge sys_clk) disable iff (rst)
    loopback_select == `LB_NEAR_PCS |=> loopback_path == 4'h1)
    else $error("Loopback decode wrong");
endmodule : lane_sideband

// ===== lane_far_end.sv
// Far-side line model: pattern wrap, squelch bursts, receiver presence
`timescale 1ns/1ps
module lane_far_end (
  input wire logic sys_clk,
  input wire logic tx_pattern_bit,
  output logic rx_pattern_bit_in,
  output logic oob_squelch_pin,
  output logic far_present_pin
);
  // The line wraps the transmitted pattern straight back
  assign rx_pattern_bit_in = tx_pattern_bit;
  initial begin
    oob_squelch_pin = 1'b0;
    far_present_pin = 1'b0;
  end
  task automatic attach(input logic v);
    far_present_pin = v;
  endtask : attach
  // Bursts of 13 cycles, each after an idle gap of the chosen length
  task automatic send_oob(input int gap, input int n);
    repeat (n) begin
      repeat (gap) @(posedge sys_clk);
      oob_squelch_pin <= 1'b1;
      repeat (13) @(posedge sys_clk);
      oob_squelch_pin <= 1'b0;
    end
  endtask : send_oob
endmodule : lane_far_end

// ===== serdes_pipe_oob_prbs_sideband_bench.sv
// Self-checking bench for the lane sideband block
`timescale 1ns/1ps
`include "pipe_sb_map.svh"
module serdes_pipe_oob_prbs_sideband_bench;
  import pipe_sb_pkg::*;
  logic sys_clk, rst, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr, rx_k_in, rx_control_char_flags, loopback_path;
  word_t reg_wdata, reg_rdata;
  pwr_t tx_power_state, rx_power_state;
  logic tx_idle_request, far_receiver_detect_req, tx_pattern_inject_error;
  logic tx_disparity_mode, tx_disparity_value, oob_wake_send;
  logic tx_oob_burst, oob_send_done;
  logic rx_lock_in, rx_data_valid_in, rx_pattern_bit_in;
  logic oob_squelch_pin, far_present_pin, rx_symbol_valid;
  logic phy_op_complete, tx_elec_idle, tx_pattern_bit, rx_pattern_error;
  logic [2:0] loopback_select, tx_pattern_select, rx_status_code;
  logic [31:0] rx_word_in, rx_word;
  logic [2:0] lbs [6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h0, 3'h3};
  logic [3:0] lbp [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0};
  int gaps [4] = '{12, 40, 120, 12};
  word_t ctl [4] = '{16'h0022, 16'h0022, 16'h0022, 16'h0020};
  word_t oobx [4] = '{16'h0008, 16'h0002, 16'h0004, 16'h0000};
  int failures = 0;
  int tests_run = 0;

  lane_sideband u_lane_sideband (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_power_state, .rx_power_state,
    .tx_idle_request, .tx_disparity_mode, .tx_disparity_value,
    .far_receiver_detect_req, .loopback_select, .oob_init_send(1'b0),
    .oob_sas_send(1'b0), .oob_wake_send, .tx_pattern_select,
    .tx_pattern_inject_error, .rx_lock_in, .rx_data_valid_in, .rx_word_in,
    .rx_k_in, .rx_pattern_bit_in, .oob_squelch_pin, .far_present_pin,
    .rx_status_code, .rx_symbol_valid, .rx_word, .rx_control_char_flags,
    .oob_init_detected(), .oob_sas_detected(), .oob_wake_detected(),
    .oob_send_done, .phy_op_complete, .tx_elec_idle, .tx_oob_burst,
    .loopback_path, .tx_pattern_bit, .rx_pattern_error);

  lane_far_end u_lane_far_end (.sys_clk, .tx_pattern_bit, .rx_pattern_bit_in,
    .oob_squelch_pin, .far_present_pin);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output word_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdchk(input logic [3:0] a, input word_t x);
    word_t d;
    rd(a, d);
    check(d, x);
  endtask : rdchk

  // Counts edges until the completion pulse; a missing pulse gives lim, or ends the run when must is set
  task automatic wait_op(input int lim, input bit must, output int n);
    n = 0;
    while (n < lim) begin
      @(posedge sys_clk);
      n++;
      #1;
      if (phy_op_complete === 1'b1) return;
    end
    if (must) begin
      failures++;
      close_out();
    end
  endtask : wait_op

  task automatic pwr(input pwr_t v, output int n);
    @(posedge sys_clk);
    tx_power_state <= v;
    rx_power_state <= v;
    wait_op(400, 1'b1, n);
  endtask : pwr

  task automatic pat_run(input logic inj, output int e);
    repeat (80) @(posedge sys_clk);
    tx_pattern_inject_error <= inj;
    @(posedge sys_clk);
    tx_pattern_inject_error <= 1'b0;
    e = 0;
    repeat (60) begin
      @(posedge sys_clk);
      #1;
      if (rx_pattern_error === 1'b1) e++;
    end
  endtask : pat_run

  initial begin
    int n;
    int e;
    word_t d;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 22'h0};
    {tx_power_state, rx_power_state, tx_idle_request} = 5'h0;
    {far_receiver_detect_req, tx_pattern_inject_error, oob_wake_send} = 3'h0;
    {tx_disparity_mode, tx_disparity_value} = 2'h0;
    {rx_lock_in, rx_data_valid_in, rx_word_in, rx_k_in} = 38'h0;
    {loopback_select, tx_pattern_select} = 6'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 check(tx_elec_idle, 1'b1);
    rdchk(`RA_CTRL, 16'h0042);
    rdchk(`RA_P2_IN, 16'h0064);
    rdchk(`RA_P2_OUT, 16'h003c);
    rdchk(`RA_NONP2, 16'h0019);
    rdchk(`RA_MASK, 16'h0000);
    wr(4'h7, 16'hffff);
    rdchk(4'h7, 16'h0000);
    wr(`RA_STAT, 16'h003f);
    rdchk(`RA_STAT, 16'h0000);
    wr(`RA_P2_IN, 16'hffff);
    rdchk(`RA_P2_IN, 16'hffff);
    $display("registers finished, %0d checks", tests_run);

    wr(`RA_NONP2, 16'h0003);
    wr(`RA_P2_IN, 16'h0005);
    wr(`RA_P2_OUT, 16'h0002);
    pwr(2'h2, n);
    check(n, 5);
    pwr(2'h3, n);
    check(n, 7);
    pwr(2'h0, n);
    check(n, 4);
    @(posedge sys_clk);
    tx_power_state <= 2'h2;
    repeat (2) @(posedge sys_clk);
    pwr(2'h0, n);
    check(n, 5);
    check(irq, 1'b0);
    wr(`RA_MASK, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1 check(irq, 1'b1);
    rdchk(`RA_STAT, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1 check(irq, 1'b0);
    wr(`RA_MASK, 16'h0000);
    $display("power finished, %0d checks", tests_run);

    @(posedge sys_clk);
    tx_idle_request <= 1'b1;
    pwr(2'h2, n);
    for (int p = 1; p >= 0; p--) begin
      u_lane_far_end.attach(p[0]);
      @(posedge sys_clk);
      far_receiver_detect_req <= 1'b1;
      wait_op(300, 1'b1, n);
      far_receiver_detect_req <= 1'b0;
      check(rx_status_code, p ? 3'h3 : 3'h0);
      check(n >= 125 && n <= 127, 1'b1);
    end
    // Refused detects: SATA format, then each disparity input set
    for (int c = 0; c < 3; c++) begin
      wr(`RA_CTRL, c ? 16'h0042 : 16'h0043);
      {tx_disparity_value, tx_disparity_mode} <= c[1:0];
      @(posedge sys_clk);
      far_receiver_detect_req <= 1'b1;
      wait_op(200, 1'b0, n);
      check(n, 200);
      @(posedge sys_clk);
      far_receiver_detect_req <= 1'b0;
    end
    {tx_disparity_value, tx_disparity_mode} <= 2'h0;
    tx_idle_request <= 1'b0;
    pwr(2'h0, n);
    repeat (2) @(posedge sys_clk);
    #1 check(tx_elec_idle, 1'b0);
    @(posedge sys_clk);
    tx_idle_request <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(tx_elec_idle, 1'b1);
    tx_idle_request <= 1'b0;
    $display("detect finished, %0d checks", tests_run);

    foreach (lbs[i]) begin
      @(posedge sys_clk);
      loopback_select <= lbs[i];
      repeat (2) @(posedge sys_clk);
      #1 check(loopback_path, lbp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {rx_lock_in, rx_data_valid_in} <= i[1:0];
      rx_word_in <= 32'h5a5a0000 + i;
      rx_k_in <= 4'h1 << i;
      repeat (2) @(posedge sys_clk);
      #1 check(rx_symbol_valid, i == 3);
      check(rx_word, 32'h5a5a0000 + i);
      check(rx_control_char_flags, 4'h1 << i);
    end
    rdchk(`RA_STATE, 16'h0400);
    $display("loopback and valid finished, %0d checks", tests_run);

    rd(`RA_STAT, d);
    foreach (gaps[i]) begin
      wr(`RA_CTRL, ctl[i]);
      u_lane_far_end.send_oob(gaps[i], 4);
      repeat (10) @(posedge sys_clk);
      rdchk(`RA_STAT, oobx[i]);
    end
    // Wake send with two bursts: 13 cycles high, 13 low, each
    @(posedge sys_clk);
    oob_wake_send <= 1'b1;
    @(posedge sys_clk);
    oob_wake_send <= 1'b0;
    #1 n = 0;
    e = 0;
    while (oob_send_done !== 1'b1 && n < 300) begin
      if (tx_oob_burst === 1'b1) e++;
      @(posedge sys_clk);
      #1 n++;
    end
    check(n, 52);
    check(e, 26);
    if (n >= 300) close_out();
    rdchk(`RA_STAT, 16'h0020);
    $display("out-of-band finished, %0d checks", tests_run);

    wr(`RA_CTRL, 16'h0044);
    for (int s = 1; s <= 4; s++) begin
      @(posedge sys_clk);
      tx_pattern_select <= s[2:0];
      for (int f = 0; f < 2; f++) begin
        pat_run(f[0], e);
        check(e != 0, f[0]);
      end
    end
    // Error loop keeps re-injecting after a single forced error
    wr(`RA_CTRL, 16'h004c);
    pat_run(1'b1, e);
    check(e > 3, 1'b1);
    wr(`RA_CTRL, 16'h0040);
    pat_run(1'b1, e);
    check(e, 0);
    $display("pattern finished, %0d checks", tests_run);
    close_out();
  end
endmodule : serdes_pipe_oob_prbs_sideband_bench
